/* design/clk_tree_pkg.sv */
// constants for the clock tree controller: register map, field positions, codes
// assumes a single 25 MHz core clock that stands in for the 64 MHz fast root
package clk_tree_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int CLK_PERIOD_NS = 40;
    // register byte offsets
    localparam logic [7:0] FAST_CFG_OFS = 8'h00;
    localparam logic [7:0] SLOW_CFG_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    // fast configuration fields
    localparam int FSRC_LSB = 0;
    localparam int SDIV_LSB = 2;
    localparam int RDIV_LSB = 4;
    // slow configuration fields
    localparam int SLOW_EN_BIT = 0;
    localparam int SLOW_SEL_LSB = 1;
    localparam int SLOW_OUT_BIT = 3;
    localparam int FAST_OUT_BIT = 4;
    localparam int FAST_OUT_SEL_LSB = 5;
    localparam int I2S_MODE_BIT = 7;
    localparam int I2S_32_BIT = 8;
    // values after reset
    localparam logic [1:0] FSRC_RESET = 2'h0;
    localparam logic [1:0] SDIV_RESET = 2'h2;
    localparam logic [1:0] RDIV_RESET = 2'h0;
    localparam logic [8:0] SLOW_CFG_RESET = 9'h000;
    // cycle counts
    localparam int SLOW_DIV = 512;
    localparam int FIX32_DIV = 2;
    localparam int FIX16_DIV = 4;
    localparam int PKE_DIV = 2;

    typedef enum logic [1:0] {
        SRC_FAST_RC = 2'b00,
        SRC_PLL = 2'b01,
        SRC_CRYSTAL = 2'b10
    } fast_src_t;

    typedef enum logic [1:0] {
        SLOW_RC = 2'b00,
        SLOW_EXT = 2'b01,
        SLOW_DIVIDED = 2'b10,
        SLOW_PMU = 2'b11
    } slow_src_t;

    typedef enum logic [1:0] {
        FOUT_SYS = 2'b00,
        FOUT_FIX32 = 2'b01,
        FOUT_FIX16 = 2'b10,
        FOUT_ROOT = 2'b11
    } fast_out_t;

    // divider code 0,1,2,3 gives /1,/2,/4,/8
    function automatic logic [3:0] div_of(input logic [1:0] code);
        div_of = 4'h1 << code;
    endfunction
endpackage

/* design/sys_switch_if.sv */
// carries the system clock request and the switched result between the controller
// and its glitch-free switch; one clock domain only
`timescale 1ns/1ps
interface sys_switch_if;
    logic [1:0] src_req;
    logic [1:0] div_req;
    logic src_ok;
    logic run;
    logic sys_tick;
    logic [1:0] src_act;
    logic [1:0] div_act;
    modport ctl (output src_req, output div_req, output src_ok, output run,
        input sys_tick, input src_act, input div_act);
    modport sw (input src_req, input div_req, input src_ok, input run,
        output sys_tick, output src_act, output div_act);
endinterface

/* design/rate_div.sv */
// divides a tick enable by a fixed count; one-cycle output pulse on the last input tick
// assumes i_tick is a one-cycle pulse on i_clk
`timescale 1ns/1ps
module rate_div #(
    parameter int DIV = 4
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_tick,
    output logic o_tick
);
    localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);
    logic [W-1:0] count;

    // refused at elaboration: a zero or negative count has no last tick
    if (DIV < 1) begin
        $error("rate_div: DIV must be at least 1");
    end

    always_ff @(posedge i_clk) begin
        if (i_rst || (i_tick && count == LAST)) begin
            count <= '0;
        end else if (i_tick) begin
            count <= count + W'(1);
        end
    end

    assign o_tick = i_tick && count == LAST;
endmodule

/* design/sys_switch.sv */
// glitch-free system clock switch: source and divider change only at a period boundary or while stopped
// assumes i_clk models the 64 MHz root and the crystal runs at half that rate
`timescale 1ns/1ps
module sys_switch (
    input wire logic i_clk,
    input wire logic i_rst,
    sys_switch_if.sw sw
);
    import clk_tree_pkg::*;
    logic [3:0] count;
    logic half;
    logic root_tick;
    logic boundary;

    // the crystal is the 32 MHz source, so it ticks every second root cycle
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            half <= 1'b0;
        end else begin
            half <= ~half;
        end
    end

    assign root_tick = sw.run && (sw.src_act != SRC_CRYSTAL || half);
    assign boundary = root_tick && (count == div_of(sw.div_act) - 4'h1);

    always_ff @(posedge i_clk) begin
        if (i_rst || boundary) begin
            count <= 4'h0;
        end else if (root_tick) begin
            count <= count + 4'h1;
        end
    end

    // new settings wait for the end of the running period, never cutting it short
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sw.src_act <= FSRC_RESET;
            sw.div_act <= SDIV_RESET;
        end else if (boundary || !sw.run) begin
            sw.div_act <= sw.div_req;
            if (sw.src_ok) begin
                sw.src_act <= sw.src_req;
            end
        end
    end

    assign sw.sys_tick = boundary;
endmodule

/* design/clk_tree_ctrl.sv */
// clock tree controller: fast and slow source selection, system divider, fixed clocks,
// peripheral clock enables and clock output pins, with an APB register slave
// assumes every clock is a one-cycle enable on I_CLK, and slow source ticks arrive synchronous
// Overview of operation
// - system clock runs from exactly one of fast rc, pll or crystal
// - slow tree picks slow rc, external slow, divided fast, or power-unit clock
// - divided slow option is 16 MHz over 512, absent in deep stop
// - after reset every slow source stays off until software enables one
// - fast block gives pll clock only with crystal present and lock, else rc
// - out of reset the root clock is divided by four
// - fixed 32 and 16 MHz clocks keep their rate across system switches
// - slow and fast clocks reach output pins only when software routes them
// - serial baud logic always runs on the fixed 16 MHz clock
// - spi takes fixed 16 or 32 MHz in i2s mode, system clock otherwise
// - random source gets fixed 16 MHz besides the system clock
// - flash controller gets fixed 16 MHz for program and erase timing
// - public key engine gets an extra clock at half system rate
// - radio bus uses system clock over 1, 2 or 4 plus fixed 16 and 32
// - converter kernel clock is the 64 MHz root prescaled to 16 MHz
// - slow tree clocks radio timers, real-time clock and watchdog
// - slow enable and selection hold through deep stop and wakeup
// - deep stop halts system and bus clocks, slow clock may run
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
module clk_tree_ctrl (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_crystal_ready,
    input wire logic i_pll_lock,
    input wire logic i_deep_stop,
    input wire logic i_slow_rc_tick,
    input wire logic i_slow_ext_tick,
    input wire logic i_pmu_slow_tick,
    output logic [1:0] o_fast_block_src,
    output logic o_sys_en,
    output logic o_fix32_en,
    output logic o_fix16_en,
    output logic o_serial_en,
    output logic o_spi_en,
    output logic o_rng_fix_en,
    output logic o_flash_fix_en,
    output logic o_pke_half_en,
    output logic o_radio_bus_en,
    output logic o_radio_fix16_en,
    output logic o_radio_fix32_en,
    output logic o_adc_kernel_en,
    output logic o_slow_en,
    output logic o_slow_out,
    output logic o_slow_out_oe,
    output logic o_fast_out,
    output logic o_fast_out_oe
);
    import clk_tree_pkg::*;

    sys_switch_if swi ();

    logic [1:0] fsrc;
    logic [1:0] sdiv;
    logic [1:0] rdiv;
    logic [8:0] slow_cfg;
    logic fast_run;
    logic [1:0] fix_count;
    logic fix32;
    logic fix16;
    logic pll_ok;
    logic slow_div_tick;
    logic next_slow;
    logic slow_tick;
    logic pke_tick;
    logic [1:0] radio_count;
    logic [3:0] radio_last;
    logic radio_tick;
    logic fast_sel_tick;
    logic wr;
    logic rd;
    logic [31:0] next_rdata;
    logic hit;

    assign wr = i_psel && i_penable && i_pwrite;
    assign rd = i_psel && i_penable && !i_pwrite;
    assign hit = i_paddr == FAST_CFG_OFS || i_paddr == SLOW_CFG_OFS || i_paddr == STATUS_OFS;

    // zero-wait slave; unmapped addresses answer with an error and read as zero
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !hit;

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            fsrc <= FSRC_RESET;
            sdiv <= SDIV_RESET;
            rdiv <= RDIV_RESET;
        end else if (wr && i_paddr == FAST_CFG_OFS) begin
            fsrc <= i_pwdata[FSRC_LSB +: 2] == 2'h3 ? fsrc : i_pwdata[FSRC_LSB +: 2];
            sdiv <= i_pwdata[SDIV_LSB +: 2];
            rdiv <= i_pwdata[RDIV_LSB +: 2] == 2'h3 ? rdiv : i_pwdata[RDIV_LSB +: 2];
        end
    end

    // cleared only by system reset; deep stop leaves it untouched
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            slow_cfg <= SLOW_CFG_RESET;
        end else if (wr && i_paddr == SLOW_CFG_OFS) begin
            slow_cfg <= i_pwdata[8:0];
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (i_paddr == FAST_CFG_OFS) begin
            next_rdata[5:0] = {rdiv, sdiv, fsrc};
        end else if (i_paddr == SLOW_CFG_OFS) begin
            next_rdata[8:0] = slow_cfg;
        end else if (i_paddr == STATUS_OFS) begin
            next_rdata[7:0] = {o_slow_en, pll_ok, swi.div_act, swi.src_act, o_fast_block_src};
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            o_prdata <= 32'h0000_0000;
        end else if (i_psel && !i_penable && !i_pwrite) begin
            o_prdata <= next_rdata;
        end
    end

    // pll counts as accurate only while the crystal feeds it and it holds lock
    assign pll_ok = i_crystal_ready && i_pll_lock;
    assign o_fast_block_src = pll_ok ? SRC_PLL : SRC_FAST_RC;
    assign fast_run = !i_deep_stop;

    always_comb begin
        swi.src_req = fsrc;
        swi.div_req = sdiv;
        swi.run = fast_run;
        case (fsrc)
            SRC_PLL: swi.src_ok = pll_ok;
            SRC_CRYSTAL: swi.src_ok = i_crystal_ready;
            default: swi.src_ok = 1'b1;
        endcase
    end

    sys_switch u_switch (
        .i_clk(I_CLK),
        .i_rst(I_SYS_RST),
        .sw(swi.sw)
    );

    // fixed clocks come straight off the root, not off the system divider
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            fix_count <= 2'h0;
        end else if (fast_run) begin
            fix_count <= fix_count + 2'h1;
        end
    end

    assign fix32 = fast_run && fix_count[0];
    assign fix16 = fast_run && fix_count == 2'(FIX16_DIV - 1);

    rate_div #(.DIV(SLOW_DIV)) u_slow_div (
        .i_clk(I_CLK),
        .i_rst(I_SYS_RST),
        .i_tick(fix16),
        .o_tick(slow_div_tick)
    );

    rate_div #(.DIV(PKE_DIV)) u_pke_div (
        .i_clk(I_CLK),
        .i_rst(I_SYS_RST),
        .i_tick(swi.sys_tick),
        .o_tick(pke_tick)
    );

    // compare with >= so a shorter divider set mid-period wraps at once
    assign radio_last = div_of(rdiv) - 4'h1;

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST || (swi.sys_tick && radio_count >= radio_last[1:0])) begin
            radio_count <= 2'h0;
        end else if (swi.sys_tick) begin
            radio_count <= radio_count + 2'h1;
        end
    end

    assign radio_tick = swi.sys_tick && radio_count >= radio_last[1:0];

    always_comb begin
        case (slow_src_t'(slow_cfg[SLOW_SEL_LSB +: 2]))
            SLOW_RC: next_slow = i_slow_rc_tick;
            SLOW_EXT: next_slow = i_slow_ext_tick;
            SLOW_DIVIDED: next_slow = slow_div_tick;
            SLOW_PMU: next_slow = i_pmu_slow_tick;
            default: next_slow = 1'b0;
        endcase
    end

    // the divided option dies with the fast root in deep stop
    assign slow_tick = slow_cfg[SLOW_EN_BIT] && next_slow;

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            o_sys_en <= 1'b0;
            o_fix32_en <= 1'b0;
            o_fix16_en <= 1'b0;
            o_serial_en <= 1'b0;
            o_spi_en <= 1'b0;
            o_rng_fix_en <= 1'b0;
            o_flash_fix_en <= 1'b0;
            o_pke_half_en <= 1'b0;
            o_radio_bus_en <= 1'b0;
            o_radio_fix16_en <= 1'b0;
            o_radio_fix32_en <= 1'b0;
            o_adc_kernel_en <= 1'b0;
            o_slow_en <= 1'b0;
        end else begin
            o_sys_en <= swi.sys_tick;
            o_fix32_en <= fix32;
            o_fix16_en <= fix16;
            o_serial_en <= fix16;
            if (slow_cfg[I2S_MODE_BIT]) begin
                o_spi_en <= slow_cfg[I2S_32_BIT] ? fix32 : fix16;
            end else begin
                o_spi_en <= swi.sys_tick;
            end
            o_rng_fix_en <= fix16;
            o_flash_fix_en <= fix16;
            o_pke_half_en <= pke_tick;
            o_radio_bus_en <= radio_tick;
            o_radio_fix16_en <= fix16;
            o_radio_fix32_en <= fix32;
            o_adc_kernel_en <= fix16;
            o_slow_en <= slow_tick;
        end
    end

    always_comb begin
        case (fast_out_t'(slow_cfg[FAST_OUT_SEL_LSB +: 2]))
            FOUT_SYS: fast_sel_tick = swi.sys_tick;
            FOUT_FIX32: fast_sel_tick = fix32;
            FOUT_FIX16: fast_sel_tick = fix16;
            FOUT_ROOT: fast_sel_tick = fast_run;
            default: fast_sel_tick = 1'b0;
        endcase
    end

    // pins toggle on each selected tick, giving a square wave at half the tick rate
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            o_slow_out <= 1'b0;
            o_fast_out <= 1'b0;
            o_slow_out_oe <= 1'b0;
            o_fast_out_oe <= 1'b0;
        end else begin
            o_slow_out_oe <= slow_cfg[SLOW_OUT_BIT];
            o_fast_out_oe <= slow_cfg[FAST_OUT_BIT];
            if (!slow_cfg[SLOW_OUT_BIT]) begin
                o_slow_out <= 1'b0;
            end else if (slow_tick) begin
                o_slow_out <= ~o_slow_out;
            end
            if (!slow_cfg[FAST_OUT_BIT]) begin
                o_fast_out <= 1'b0;
            end else if (fast_sel_tick) begin
                o_fast_out <= ~o_fast_out;
            end
        end
    end

    pll_gate_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        o_fast_block_src == SRC_PLL |-> i_crystal_ready && i_pll_lock)
        else $error("fast block reports pll without crystal and lock");

    slow_off_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        !slow_cfg[SLOW_EN_BIT] |=> !o_slow_en)
        else $error("slow clock runs while disabled");

    reset_div_a: assert property (@(posedge I_CLK)
        $fell(I_SYS_RST) |-> swi.div_act == 2'h2 && sdiv == 2'h2)
        else $error("system divider not four after reset");

    fix16_rate_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST || i_deep_stop)
        o_fix16_en |=> !o_fix16_en ##1 !o_fix16_en ##1 !o_fix16_en ##1 (o_fix16_en || $past(i_deep_stop)))
        else $error("fixed 16 MHz enable lost its rate");

    serial_fix_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        o_serial_en == o_fix16_en && o_rng_fix_en == o_fix16_en && o_flash_fix_en == o_fix16_en)
        else $error("serial, random or flash clock left the fixed 16 MHz");

    spi_i2s_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        slow_cfg[I2S_MODE_BIT] && slow_cfg[I2S_32_BIT] |=> o_spi_en == $past(fix32))
        else $error("spi in i2s mode not on fixed 32 MHz");

    pke_half_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        o_pke_half_en |-> o_sys_en)
        else $error("public key clock not aligned to system clock");

    deep_stop_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        i_deep_stop ##1 i_deep_stop |=> !o_sys_en && !o_fix16_en)
        else $error("fast clocks running in deep stop");

    slow_div_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        slow_div_tick |-> fix16)
        else $error("divided slow clock not on a 16 MHz edge");

    pin_route_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        !o_slow_out_oe ##1 !o_slow_out_oe |-> !o_slow_out)
        else $error("slow clock pin toggles while not routed");
endmodule

/* sim/clk_tree_ctrl_bench.sv */
// self-checking bench for the clock tree controller: apb tasks and tick counting
// assumes every clock output is a one-cycle enable on I_CLK and slow ticks come from this bench
`timescale 1ns/1ps
module clk_tree_ctrl_bench;
    import clk_tree_pkg::*;
    logic I_CLK = 1'b0;
    logic I_SYS_RST = 1'b1;
    logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h00000000;
    logic i_crystal_ready = 1'b0, i_pll_lock = 1'b0, i_deep_stop = 1'b0;
    logic i_slow_rc_tick = 1'b0, i_slow_ext_tick = 1'b0, i_pmu_slow_tick = 1'b0;
    logic [31:0] o_prdata;
    logic o_pready, o_pslverr;
    logic [1:0] o_fast_block_src;
    logic o_sys_en, o_fix32_en, o_fix16_en, o_serial_en, o_spi_en, o_rng_fix_en, o_flash_fix_en;
    logic o_pke_half_en, o_radio_bus_en, o_radio_fix16_en, o_radio_fix32_en, o_adc_kernel_en;
    logic o_slow_en, o_slow_out, o_slow_out_oe, o_fast_out, o_fast_out_oe;
    logic [7:0] tcnt = 8'h00;
    logic [12:0] sigs;
    logic [31:0] rd;
    logic err;
    int cnt [0:14];
    int errors = 0;
    int compares = 0;
    int r, k;
    int sels [3] = '{0, 1, 3};
    int slow_exp [3] = '{8, 4, 2};
    int fout_exp [4] = '{64, 32, 16, 64};

    clk_tree_ctrl dut (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_crystal_ready(i_crystal_ready),
        .i_pll_lock(i_pll_lock), .i_deep_stop(i_deep_stop), .i_slow_rc_tick(i_slow_rc_tick),
        .i_slow_ext_tick(i_slow_ext_tick), .i_pmu_slow_tick(i_pmu_slow_tick),
        .o_fast_block_src(o_fast_block_src), .o_sys_en(o_sys_en), .o_fix32_en(o_fix32_en),
        .o_fix16_en(o_fix16_en), .o_serial_en(o_serial_en), .o_spi_en(o_spi_en),
        .o_rng_fix_en(o_rng_fix_en), .o_flash_fix_en(o_flash_fix_en), .o_pke_half_en(o_pke_half_en),
        .o_radio_bus_en(o_radio_bus_en), .o_radio_fix16_en(o_radio_fix16_en),
        .o_radio_fix32_en(o_radio_fix32_en), .o_adc_kernel_en(o_adc_kernel_en), .o_slow_en(o_slow_en),
        .o_slow_out(o_slow_out), .o_slow_out_oe(o_slow_out_oe), .o_fast_out(o_fast_out),
        .o_fast_out_oe(o_fast_out_oe));

    // bit 0 is the system tick; index order is used by the count checks below
    assign sigs = {o_slow_en, o_adc_kernel_en, o_radio_fix32_en, o_radio_fix16_en, o_radio_bus_en,
        o_pke_half_en, o_flash_fix_en, o_rng_fix_en, o_spi_en, o_serial_en, o_fix16_en, o_fix32_en, o_sys_en};

    initial begin
        forever #20 I_CLK = ~I_CLK;
    end

    // slow sources run free at periods of 8, 16 and 32 cycles, also in deep stop
    always_ff @(posedge I_CLK) begin
        tcnt <= tcnt + 8'h01;
        i_slow_rc_tick <= (tcnt[2:0] == 3'h7);
        i_slow_ext_tick <= (tcnt[3:0] == 4'hF);
        i_pmu_slow_tick <= (tcnt[4:0] == 5'h1F);
    end

    task automatic print_verdict();
        $display("mismatches %0d, comparisons %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %0h, seen %0h", name, exp, got);
        end
    endtask

    task automatic cc(input string name, input int idx, input int exp);
        check(name, 32'(exp), 32'(cnt[idx]));
    endtask

    // pready is sampled at each access edge; data and error are taken at that edge only
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge I_CLK);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge I_CLK);
        i_penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge I_CLK);
            if (o_pready === 1'b1) break;
        end
        if (i == 16) begin
            errors++;
            print_verdict();
        end else begin
            rd = o_prdata;
            err = o_pslverr;
            i_psel <= 1'b0;
            i_penable <= 1'b0;
        end
    endtask

    // counts pulses of every enable and toggles of both pins over n cycles
    task automatic count(input int n);
        logic ps, pf;
        for (k = 0; k < 15; k++) cnt[k] = 0;
        @(negedge I_CLK);
        ps = o_slow_out;
        pf = o_fast_out;
        repeat (n) begin
            @(negedge I_CLK);
            for (k = 0; k < 13; k++) if (sigs[k] === 1'b1) cnt[k]++;
            if (o_slow_out !== ps) cnt[13]++;
            if (o_fast_out !== pf) cnt[14]++;
            ps = o_slow_out;
            pf = o_fast_out;
        end
    endtask

    // settling covers the wait for a system period boundary before a switch lands
    task automatic wr_count(input logic [7:0] a, input logic [31:0] d, input int n);
        apb(1'b1, a, d);
        repeat (20) @(posedge I_CLK);
        count(n);
    endtask

    initial begin
        repeat (6) @(posedge I_CLK);
        I_SYS_RST <= 1'b0;
        apb(1'b0, FAST_CFG_OFS, 32'h0);
        check("fast cfg", 32'(SDIV_RESET) << SDIV_LSB, rd);
        apb(1'b0, SLOW_CFG_OFS, 32'h0);
        check("slow cfg", 32'h0, rd);
        count(64);
        cc("sys tick", 0, 16);
        cc("fix32", 1, 32);
        cc("fix16", 2, 16);
        cc("pke half", 7, 8);
        cc("spi", 4, 16);
        cc("slow tick", 12, 0);
        check("pin oe", 32'h0, 32'({o_slow_out_oe, o_fast_out_oe}));
        $display("test reset done");
        for (r = 0; r < 3; r++) begin
            wr_count(FAST_CFG_OFS, 32'(r) << RDIV_LSB, 64);
            cc("sys tick", 0, 64);
            cc("radio bus", 8, 64 >> r);
            cc("pke half", 7, 32);
            for (k = 1; k < 12; k++) begin
                if (k != 4 && k != 7 && k != 8) begin
                    cc($sformatf("fixed %0d", k), k, (k == 1 || k == 10) ? 32 : 16);
                end
            end
        end
        apb(1'b1, FAST_CFG_OFS, 32'h30);
        apb(1'b0, FAST_CFG_OFS, 32'h0);
        check("radio code", 32'h20, rd);
        $display("test dividers done");
        wr_count(FAST_CFG_OFS, 32'h1, 8);
        apb(1'b0, STATUS_OFS, 32'h0);
        check("active src", 32'h0, (rd >> 2) & 32'h3);
        i_pll_lock <= 1'b1;
        count(4);
        check("fast block src", 32'h0, 32'(o_fast_block_src));
        @(posedge I_CLK);
        i_crystal_ready <= 1'b1;
        count(4);
        check("fast block src", 32'h1, 32'(o_fast_block_src));
        for (r = 1; r < 4; r++) begin
            wr_count(FAST_CFG_OFS, 32'(r), 64);
            apb(1'b0, STATUS_OFS, 32'h0);
            check("active src", (r == 3) ? 32'h2 : 32'(r), (rd >> 2) & 32'h3);
            cc("sys tick", 0, (r == 1) ? 64 : 32);
        end
        wr_count(FAST_CFG_OFS, 32'h0, 8);
        $display("test source done");
        for (r = 0; r < 3; r++) begin
            wr_count(SLOW_CFG_OFS, 32'h9 | (32'(sels[r]) << SLOW_SEL_LSB), 64);
            cc("slow tick", 12, slow_exp[r]);
            cc("slow pin", 13, slow_exp[r]);
            check("slow oe", 32'h1, 32'(o_slow_out_oe));
        end
        wr_count(SLOW_CFG_OFS, 32'h1 | (32'(SLOW_DIVIDED) << SLOW_SEL_LSB), 4096);
        cc("slow divided", 12, 2);
        check("slow pin", 32'h0, 32'({o_slow_out_oe, o_slow_out}));
        @(posedge I_CLK);
        i_deep_stop <= 1'b1;
        count(4096);
        cc("slow divided", 12, 0);
        cc("sys tick", 0, 0);
        cc("radio bus", 8, 0);
        @(posedge I_CLK);
        i_deep_stop <= 1'b0;
        apb(1'b1, SLOW_CFG_OFS, 32'h3);
        i_deep_stop <= 1'b1;
        count(64);
        cc("slow in stop", 12, 4);
        @(posedge I_CLK);
        i_deep_stop <= 1'b0;
        apb(1'b0, SLOW_CFG_OFS, 32'h0);
        check("slow cfg", 32'h3, rd);
        $display("test slow done");
        // system runs at /1 here, so the system and root selections toggle every cycle
        for (r = 0; r < 4; r++) begin
            wr_count(SLOW_CFG_OFS, (32'h1 << FAST_OUT_BIT) | (32'(r) << FAST_OUT_SEL_LSB), 64);
            cc("fast pin", 14, fout_exp[r]);
            check("fast oe", 32'h1, 32'(o_fast_out_oe));
        end
        wr_count(SLOW_CFG_OFS, (32'h1 << I2S_MODE_BIT) | (32'h1 << I2S_32_BIT), 64);
        cc("spi i2s32", 4, 32);
        wr_count(SLOW_CFG_OFS, 32'h1 << I2S_MODE_BIT, 64);
        cc("spi i2s16", 4, 16);
        wr_count(SLOW_CFG_OFS, 32'h0, 64);
        cc("spi sys", 4, 64);
        check("fast pin idle", 32'h0, 32'({o_fast_out_oe, o_fast_out}));
        apb(1'b0, 8'h0C, 32'h0);
        check("unmapped err", 32'h1, 32'(err));
        check("unmapped data", 32'h0, rd);
        check("pready", 32'h1, 32'(o_pready));
        $display("test pins done");
        print_verdict();
    end
endmodule
